// File: include/ccr_defines.svh
// ccr_defines.svh: field positions, reset values and selects of the capability words
// assumes: included by the design files by bare name
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

`define CCR_SEL_W3 3'h3
`define CCR_SEL_W4 3'h4
`define CCR_SEL_W5 3'h5

`define CCR_W3_ISA_LO 14
`define CCR_W3_ISA_HI 15
`define CCR_ISA_BOTH_BASE 2'h2
`define CCR_ISA_BOTH_COMP 2'h3
`define CCR_W3_USER_LOCAL_PRESENT 13
`define CCR_W3_EXT_IRQ_CTRL_SUPPORT 6
`define CCR_W3_VECTORED_IRQ_SUPPORT 5
`define CCR_W3_SP 4
`define CCR_W3_SM 1
`define CCR_W3_TL 0

`define CCR_W4_M 31
`define CCR_W4_IE_LO 29
`define CCR_W4_IE_HI 30
`define CCR_IE_RESET 2'h2
`define CCR_W4_AE 28
`define CCR_W4_VTLB_LO 24
`define CCR_W4_VTLB_HI 27
`define CCR_VTLB_RESET 4'h0
`define CCR_W4_KSCR_LO 16
`define CCR_W4_KSCR_HI 23
`define CCR_KSCR_RESET 8'hfc
`define CCR_ASID_NARROW 8
`define CCR_ASID_WIDE 10

`define CCR_W5_M 31
`define CCR_W5_XNP 13
`define CCR_W5_DEC 11
`define CCR_W5_DBG_BREAK_KERNEL_ONLY 6
`define CCR_W5_MVH 5
`define CCR_W5_LLB 4
`define CCR_W5_NF 0
`define CCR_W5_WMASK 32'h0000_0040
`define CCR_W5_RSV_MASK 32'h7fff_d78e
`define CCR_W5_FIXED 32'h0000_2031
`define CCR_W4_NO_AE_MASK 32'hefff_ffff
`define CCR_W4_FIXED 32'hc0fc_0000

`endif

// File: include/ccr_pkg.sv
// ccr_pkg: types shared by the capability register bank
// assumes: ccr_defines.svh is on the include path
`default_nettype none
package ccr_pkg;
	typedef logic [31:0] ccr_word_t;
	typedef logic [2:0] ccr_sel_t;
endpackage
`default_nettype wire

// File: include/ccr_acc_if.sv
// ccr_acc_if: coprocessor-move access path between the bank and its word-five store
// assumes: single core clock domain
`default_nettype none
interface ccr_acc_if;
	import ccr_pkg::*;
	logic wr;
	ccr_sel_t sel;
	ccr_word_t wdata;
	ccr_word_t word5;
	modport bank (output wr, output sel, output wdata, input word5);
	modport store (input wr, input sel, input wdata, output word5);
endinterface
`default_nettype wire

// File: src/ccr_word5_store.sv
// ccr_word5_store: holds the only writable bit of the capability words
// assumes: writes come from the bank on the core clock
`default_nettype none
`include "ccr_defines.svh"
module ccr_word5_store (
	input wire logic clk_i,
	input wire logic rstn_i,
	ccr_acc_if.store acc
);
	import ccr_pkg::*;
	typedef struct packed {
		logic brk_kernel_only;
	} ccr_w5_state_t;
	ccr_w5_state_t st, next_st;

	always_comb begin
		next_st = st;
		if (acc.wr && acc.sel == `CCR_SEL_W5) begin
			next_st.brk_kernel_only = acc.wdata[`CCR_W5_DBG_BREAK_KERNEL_ONLY]; // R21
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '0; // R16
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		acc.word5 = '0; // R20 R13
		acc.word5[`CCR_W5_XNP] = 1'b1; // R14
		acc.word5[`CCR_W5_DEC] = 1'b0; // R15
		acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY] = st.brk_kernel_only; // R16
		acc.word5[`CCR_W5_MVH] = 1'b1; // R17
		acc.word5[`CCR_W5_LLB] = 1'b1; // R18
		acc.word5[`CCR_W5_NF] = 1'b1; // R19
	end

	chk_dbg_break_kernel_only_write_take: assert property (@(posedge clk_i) disable iff (!rstn_i)
		acc.wr && acc.sel == `CCR_SEL_W5 |=> acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY] == $past(acc.wdata[`CCR_W5_DBG_BREAK_KERNEL_ONLY])) // R21
		else $error("kernel-only bit did not follow write");
	chk_dbg_break_kernel_only_hold_value: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!(acc.wr && acc.sel == `CCR_SEL_W5) |=> $stable(acc.word5)) // R21
		else $error("word five changed without write");
endmodule // ccr_word5_store
`default_nettype wire

// File: src/ccr_brk_gate.sv
// ccr_brk_gate: decides the fate of a software debug breakpoint
// assumes: privilege level is given by the pipeline in the same cycle
`default_nettype none
module ccr_brk_gate (
	input wire logic brk_exec_i,
	input wire logic kernel_mode_i,
	input wire logic kernel_only_i,
	output logic enter_debug_o,
	output logic resv_instr_o
);
	always_comb begin
		resv_instr_o = brk_exec_i && kernel_only_i && !kernel_mode_i; // R16
		enter_debug_o = brk_exec_i && !resv_instr_o; // R16
	end
endmodule // ccr_brk_gate
`default_nettype wire

// File: src/ccr_cap_regs.sv
// ccr_cap_regs: capability words three to five of the system-control coprocessor
// assumes: coprocessor moves arrive as one-cycle strobes in the core clock domain
// Overview of operation
// R1 - instruction-set field reads 2 for base boot, 3 for compressed boot
// R2 - user-local presence bit 13 of word three reads 1
// R3 - bit 6 follows the external interrupt controller attached input
// R4 - vectored interrupt bit 5 always reads 1
// R5 - small page bit 4 is fixed at 0
// R6 - smart-card extension bit 1 always reads 0
// R7 - trace logic bit 0 of word three reads 0
// R8 - bit 31 of word four reads 1, word five exists
// R9 - translation invalidate field resets to 10, both supported
// R10 - asid extend bit widens entry-high asid to 10 bits
// R11 - translation size extension bits 27:24 read 0
// R12 - kernel scratch map resets to 1111_1100, one bit per select
// R13 - bit 31 of word five always reads 0
// R14 - pair atomic absent bit 13 reads 1
// R15 - endian capability bit 11 reads 0, little-endian only
// R16 - kernel-only breakpoint bit resets 0, traps breakpoint outside kernel mode
// R17 - high-half move present bit 5 reads 1
// R18 - link bit present flag 4 reads 1
// R19 - nested fault present bit 0 reads 1
// R20 - reserved bits of word five read zero, software writes zero
// R21 - writes only change writable bits, and on the write cycle
`default_nettype none
`include "ccr_defines.svh"
module ccr_cap_regs (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire ccr_pkg::ccr_sel_t sel_i,
	input wire ccr_pkg::ccr_word_t wdata_i,
	output ccr_pkg::ccr_word_t rdata_o,
	input wire logic ext_irq_ctrl_attached_in,
	input wire logic compressed_boot_i,
	input wire logic asid_extend_i,
	input wire logic brk_exec_i,
	input wire logic kernel_mode_i,
	output logic enter_debug_o,
	output logic resv_instr_o,
	output logic [3:0] asid_width_o
);
	import ccr_pkg::*;
	typedef struct packed {
		ccr_word_t rdata;
		logic comp_boot;
		logic boot_seen;
	} ccr_top_state_t;
	ccr_top_state_t st, next_st;
	ccr_word_t word3, word4;
	ccr_acc_if acc();

	assign acc.wr = wr_i;
	assign acc.sel = sel_i;
	assign acc.wdata = wdata_i;

	ccr_word5_store u_store (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.acc(acc)
	);

	ccr_brk_gate u_gate (
		.brk_exec_i(brk_exec_i),
		.kernel_mode_i(kernel_mode_i),
		.kernel_only_i(acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY]),
		.enter_debug_o(enter_debug_o),
		.resv_instr_o(resv_instr_o)
	);

	function automatic ccr_word_t pick(input ccr_sel_t s, input ccr_word_t w3, input ccr_word_t w4,
		input ccr_word_t w5);
		case (s)
			`CCR_SEL_W3: pick = w3;
			`CCR_SEL_W4: pick = w4;
			`CCR_SEL_W5: pick = w5;
			default: pick = '0;
		endcase
	endfunction

	always_comb begin
		word3 = '0; // R5 R6 R7
		word3[`CCR_W3_ISA_HI:`CCR_W3_ISA_LO] = st.comp_boot ? `CCR_ISA_BOTH_COMP : `CCR_ISA_BOTH_BASE; // R1
		word3[`CCR_W3_USER_LOCAL_PRESENT] = 1'b1; // R2
		word3[`CCR_W3_EXT_IRQ_CTRL_SUPPORT] = ext_irq_ctrl_attached_in; // R3
		word3[`CCR_W3_VECTORED_IRQ_SUPPORT] = 1'b1; // R4
		word4 = '0;
		word4[`CCR_W4_M] = 1'b1; // R8
		word4[`CCR_W4_IE_HI:`CCR_W4_IE_LO] = `CCR_IE_RESET; // R9
		word4[`CCR_W4_AE] = asid_extend_i; // R10
		word4[`CCR_W4_VTLB_HI:`CCR_W4_VTLB_LO] = `CCR_VTLB_RESET; // R11
		word4[`CCR_W4_KSCR_HI:`CCR_W4_KSCR_LO] = `CCR_KSCR_RESET; // R12
		asid_width_o = asid_extend_i ? 4'(`CCR_ASID_WIDE) : 4'(`CCR_ASID_NARROW); // R10
	end

	always_comb begin
		next_st = st;
		if (rd_i) begin
			next_st.rdata = pick(sel_i, word3, word4, acc.word5);
		end
		// boot instruction set is caught once per reset, just after release
		next_st.boot_seen = 1'b1;
		next_st.comp_boot = st.boot_seen ? st.comp_boot : compressed_boot_i; // R1
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;

	sequence s_read_w5;
		rd_i && sel_i == `CCR_SEL_W5;
	endsequence
	sequence s_read_w4;
		rd_i && sel_i == `CCR_SEL_W4;
	endsequence
	sequence s_read_w3;
		rd_i && sel_i == `CCR_SEL_W3;
	endsequence

	chk_w5_fixed_bits: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w5 |=> (rdata_o & ~`CCR_W5_WMASK) == `CCR_W5_FIXED) // R20
		else $error("word five fixed bits wrong");
	chk_w5_top_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w5 |=> !rdata_o[`CCR_W5_M]) // R13
		else $error("word five top bit set");
	chk_w4_reset_val: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w4 |=> (rdata_o & `CCR_W4_NO_AE_MASK) == `CCR_W4_FIXED) // R8
		else $error("word four value wrong");
	chk_w4_ae_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w4 |=> rdata_o[`CCR_W4_AE] == $past(asid_extend_i)) // R10
		else $error("asid extend bit wrong");
	chk_w3_fixed_bits: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w3 |=> rdata_o[`CCR_W3_USER_LOCAL_PRESENT] && rdata_o[`CCR_W3_VECTORED_IRQ_SUPPORT] && !rdata_o[`CCR_W3_SP]
		&& !rdata_o[`CCR_W3_SM] && !rdata_o[`CCR_W3_TL]) // R2
		else $error("word three fixed bits wrong");
	chk_w3_eic_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w3 |=> rdata_o[`CCR_W3_EXT_IRQ_CTRL_SUPPORT] == $past(ext_irq_ctrl_attached_in)) // R3
		else $error("controller bit does not follow input");
	chk_w3_isa_code: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_read_w3 |=> rdata_o[`CCR_W3_ISA_HI:`CCR_W3_ISA_LO] == (st.comp_boot ? `CCR_ISA_BOTH_COMP : `CCR_ISA_BOTH_BASE)) // R1
		else $error("instruction set code wrong");
	chk_brk_user_trap: assert property (@(posedge clk_i) disable iff (!rstn_i)
		brk_exec_i && !kernel_mode_i && acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY] |-> resv_instr_o && !enter_debug_o) // R16
		else $error("user breakpoint not trapped");
	chk_brk_default_debug: assert property (@(posedge clk_i) disable iff (!rstn_i)
		brk_exec_i && !acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY] |-> enter_debug_o && !resv_instr_o) // R16
		else $error("breakpoint did not enter debug");

	sequence s_write_w3;
		wr_i && sel_i == `CCR_SEL_W3;
	endsequence

	sequence s_write_w4;
		wr_i && sel_i == `CCR_SEL_W4;
	endsequence

	sequence s_write_w5;
		wr_i && sel_i == `CCR_SEL_W5;
	endsequence

	// single fields of word three
	chk_w3_user_local_present_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
		s_read_w3 |=> rdata_o[`CCR_W3_USER_LOCAL_PRESENT])
		else $error("user-local bit not set");

	chk_w3_vectored_irq_support_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R4
		s_read_w3 |=> rdata_o[`CCR_W3_VECTORED_IRQ_SUPPORT])
		else $error("vectored interrupt bit not set");

	chk_w3_sp_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R5
		s_read_w3 |=> !rdata_o[`CCR_W3_SP])
		else $error("small page bit set");

	chk_w3_sm_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R6
		s_read_w3 |=> !rdata_o[`CCR_W3_SM])
		else $error("smart-card bit set");

	chk_w3_tl_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R7
		s_read_w3 |=> !rdata_o[`CCR_W3_TL])
		else $error("trace bit set");

	chk_w3_isa_both: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
		s_read_w3 |=> rdata_o[`CCR_W3_ISA_HI])
		else $error("instruction set code not a both-sets code");

	chk_boot_code_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
		st.boot_seen |=> $stable(st.comp_boot))
		else $error("boot code changed after first edge");

	// single fields of word four
	chk_w4_m_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R8
		s_read_w4 |=> rdata_o[`CCR_W4_M])
		else $error("word five presence bit clear");

	chk_w4_ie_code: assert property (@(posedge clk_i) disable iff (!rstn_i) // R9
		s_read_w4 |=> rdata_o[`CCR_W4_IE_HI:`CCR_W4_IE_LO] == `CCR_IE_RESET)
		else $error("invalidate field wrong");

	chk_w4_vtlb_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R11
		s_read_w4 |=> rdata_o[`CCR_W4_VTLB_HI:`CCR_W4_VTLB_LO] == `CCR_VTLB_RESET)
		else $error("size extension not zero");

	chk_w4_kscr_map: assert property (@(posedge clk_i) disable iff (!rstn_i) // R12
		s_read_w4 |=> rdata_o[`CCR_W4_KSCR_HI:`CCR_W4_KSCR_LO] == `CCR_KSCR_RESET)
		else $error("kernel scratch map wrong");

	chk_asid_width_val: assert property (@(posedge clk_i) disable iff (!rstn_i) // R10
		asid_width_o == (asid_extend_i ? 4'(`CCR_ASID_WIDE) : 4'(`CCR_ASID_NARROW)))
		else $error("asid width wrong");

	chk_w4_write_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
		s_write_w4 ##1 s_read_w4 |=> rdata_o[`CCR_W4_KSCR_HI:`CCR_W4_KSCR_LO] == `CCR_KSCR_RESET)
		else $error("word four changed by write");

	chk_w3_write_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
		s_write_w3 ##1 s_read_w3 |=> rdata_o[`CCR_W3_USER_LOCAL_PRESENT] && !rdata_o[`CCR_W3_SP])
		else $error("word three changed by write");

	// single fields of word five
	chk_w5_xnp_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R14
		s_read_w5 |=> rdata_o[`CCR_W5_XNP])
		else $error("pair atomic bit clear");

	chk_w5_dec_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R15
		s_read_w5 |=> !rdata_o[`CCR_W5_DEC])
		else $error("endian capability bit set");

	chk_w5_mvh_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R17
		s_read_w5 |=> rdata_o[`CCR_W5_MVH])
		else $error("high-half move bit clear");

	chk_w5_llb_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R18
		s_read_w5 |=> rdata_o[`CCR_W5_LLB])
		else $error("link bit flag clear");

	chk_w5_nf_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // R19
		s_read_w5 |=> rdata_o[`CCR_W5_NF])
		else $error("nested fault bit clear");

	chk_w5_rsv_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // R20
		s_read_w5 |=> (rdata_o & `CCR_W5_RSV_MASK) == '0)
		else $error("word five reserved bits set");

	chk_w5_dbg_break_kernel_only_read: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
		s_read_w5 |=> rdata_o[`CCR_W5_DBG_BREAK_KERNEL_ONLY] == $past(acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY]))
		else $error("kernel-only bit read wrong");

	chk_w5_wr_then_rd: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
		s_write_w5 ##1 s_read_w5 |=> rdata_o[`CCR_W5_DBG_BREAK_KERNEL_ONLY] == $past(wdata_i[`CCR_W5_DBG_BREAK_KERNEL_ONLY], 2))
		else $error("written kernel-only bit not read back");

	chk_dbg_break_kernel_only_after_reset: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
		$rose(rstn_i) |-> !acc.word5[`CCR_W5_DBG_BREAK_KERNEL_ONLY])
		else $error("kernel-only bit not clear after reset");

	// breakpoint gate outside the trap case
	chk_brk_kernel_debug: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
		brk_exec_i && kernel_mode_i |-> enter_debug_o && !resv_instr_o)
		else $error("kernel breakpoint did not enter debug");

	chk_brk_idle_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
		!brk_exec_i |-> !enter_debug_o && !resv_instr_o)
		else $error("gate active without breakpoint");

	chk_rdata_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
		!rd_i |=> $stable(rdata_o))
		else $error("read data changed without read");
endmodule // ccr_cap_regs
`default_nettype wire

// File: verification/ccr_cap_regs_tb.sv
// ccr_cap_regs_tb: self-checking bench for the capability register bank
// assumes: ccr_pkg is compiled first, strobes driven on the falling edge
`default_nettype none
module ccr_cap_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccr_pkg::*;

	logic clk_i;
	logic rstn_i;
	logic rd_i;
	logic wr_i;
	ccr_sel_t sel_i;
	ccr_word_t wdata_i;
	ccr_word_t rdata_o;
	logic ext_irq;
	logic boot;
	logic asid;
	logic brk;
	logic kmode;
	logic enter_debug;
	logic resv;
	logic [3:0] asid_width;
	ccr_word_t d;
	logic kb;
	int n_fail;
	int total_checks;

	ccr_cap_regs u_ccr_cap_regs (.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i), .wr_i(wr_i), .sel_i(sel_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .ext_irq_ctrl_attached_in(ext_irq), .compressed_boot_i(boot),
		.asid_extend_i(asid), .brk_exec_i(brk), .kernel_mode_i(kmode), .enter_debug_o(enter_debug),
		.resv_instr_o(resv), .asid_width_o(asid_width));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input ccr_word_t got, input ccr_word_t exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic rd(input ccr_sel_t s, output ccr_word_t v);
		@(negedge clk_i);
		rd_i = 1'b1;
		sel_i = s;
		@(negedge clk_i);
		rd_i = 1'b0;
		v = rdata_o;
	endtask

	task automatic wr(input ccr_sel_t s, input ccr_word_t v);
		@(negedge clk_i);
		wr_i = 1'b1;
		sel_i = s;
		wdata_i = v;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask

	task automatic do_reset();
		@(negedge clk_i);
		rstn_i = 1'b0;
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// cut a hang short
	initial begin
		repeat (3000) @(posedge clk_i);
		n_fail++;
		$display("mismatch at %0t: run timed out", $time);
		finish_test();
	end

	initial begin
		n_fail = 0;
		total_checks = 0;
		rstn_i = 1'b0;
		rd_i = 1'b0;
		wr_i = 1'b0;
		sel_i = 3'h0;
		wdata_i = 32'h0;
		ext_irq = 1'b1;
		boot = 1'b0;
		asid = 1'b0;
		brk = 1'b0;
		kmode = 1'b0;
		do_reset();
		rd(3'h3, d);
		chk(d & 32'h0000e073, 32'h0000a060, "word three");
		rd(3'h4, d);
		chk(d, 32'hc0fc0000, "word four");
		rd(3'h5, d);
		chk(d, 32'h00002031, "word five");
		rd(3'h0, d);
		chk(d, 32'h0, "unused select");
		rd(3'h7, d);
		chk(d, 32'h0, "unused select");
		chk({28'h0, asid_width}, 32'h8, "narrow asid");
		$display("test reset values done");
		wr(3'h3, 32'hffffffff);
		wr(3'h4, 32'hffffffff);
		rd(3'h3, d);
		chk(d & 32'h0000e073, 32'h0000a060, "word three after write");
		rd(3'h4, d);
		chk(d, 32'hc0fc0000, "word four after write");
		wr(3'h5, 32'hffffffff);
		rd(3'h5, d);
		chk(d, 32'h00002071, "word five after write");
		$display("test writes done");
		for (int k = 0; k < 4; k++) begin
			kb = k[1];
			wr(3'h5, {25'h0, kb, 6'h0});
			kmode = k[0];
			brk = 1'b1;
			#1;
			chk({31'h0, enter_debug}, {31'h0, ~(kb & ~kmode)}, "debug entry");
			chk({31'h0, resv}, {31'h0, kb & ~kmode}, "reserved trap");
			brk = 1'b0;
			#1;
			chk({30'h0, enter_debug, resv}, 32'h0, "idle gate");
			rd(3'h5, d);
			chk(d, 32'h00002031 | {25'h0, kb, 6'h0}, "word five control");
		end
		$display("test breakpoint gate done");
		ext_irq = 1'b0;
		boot = 1'b1;
		asid = 1'b1;
		do_reset();
		rd(3'h3, d);
		chk(d & 32'h0000e073, 32'h0000e020, "word three compressed boot");
		rd(3'h4, d);
		chk(d, 32'hd0fc0000, "word four extended asid");
		chk({28'h0, asid_width}, 32'ha, "wide asid");
		rd(3'h5, d);
		chk(d, 32'h00002031, "word five after second reset");
		$display("test second reset done");
		finish_test();
	end
endmodule // ccr_cap_regs_tb
`default_nettype wire
